/* verif/spf_link_properties.sv */
// Checker for the packet stream link between the source and sink ends.
// Assumes one clock, pclk, and an asynchronous active-low reset.
`default_nettype none
module spf_link_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic valid,
  input wire logic ready,
  input wire logic [31:0] data,
  input wire logic startofpacket,
  input wire logic endofpacket,
  input wire logic [1:0] empty
);
  logic in_pkt_q;
  logic in_pkt_d;
  // A packet stays open from its start beat until a taken end beat.
  assign in_pkt_d = (valid && ready) ? (!endofpacket && (startofpacket || in_pkt_q)) : in_pkt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_pkt_q <= 1'b0;
    end else begin
      in_pkt_q <= in_pkt_d;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence beat_waits;
    valid && !ready;
  endsequence
  sequence beat_taken;
    valid && ready;
  endsequence
  a_valid_holds: assert property (beat_waits |=> valid)
    else $error("valid dropped before the beat was taken");
  a_data_stable: assert property (beat_waits |=> $stable(data))
    else $error("data changed while the beat waited");
  a_flags_stable: assert property (beat_waits |=> $stable({startofpacket, endofpacket}))
    else $error("packet flags changed while the beat waited");
  a_empty_stable: assert property (beat_waits ##0 endofpacket |=> $stable(empty))
    else $error("empty changed on a waiting end beat");
  a_no_restart: assert property (valid && in_pkt_q |-> !startofpacket)
    else $error("start beat offered inside an open packet");
  a_ready_drops: assert property (beat_taken |=> !ready)
    else $error("ready stayed high while a beat was held");
  a_reset_quiet: assert property ($rose(presetn) |-> !valid && !ready)
    else $error("link active on the first edge after reset");
  a_stall_bounded: assert property (valid |-> ##[0:1000] ready)
    else $error("beat never accepted");
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench: drives both ends over APB and compares what crosses the link.
// Assumes the source and sink ends joined by one link interface on pclk.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel_src = 1'b0;
  logic psel_snk = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] src_prdata, snk_prdata;
  logic src_pready, snk_pready, src_pslverr, snk_pslverr;
  int miscompares = 0;
  int checks = 0;
  always #4 pclk = ~pclk;
  spf_link_if #(.DATA_W(32), .EMPTY_W(2)) spf_link_if_i (.pclk(pclk));
  spf_source spf_source_i (.pclk(pclk), .presetn(presetn), .link(spf_link_if_i), .psel(psel_src),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(src_prdata),
    .pready(src_pready), .pslverr(src_pslverr));
  spf_sink spf_sink_i (.pclk(pclk), .presetn(presetn), .link(spf_link_if_i), .psel(psel_snk),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(snk_prdata),
    .pready(snk_pready), .pslverr(snk_pslverr));
  spf_link_properties spf_link_properties_i (.pclk(pclk), .presetn(presetn),
    .valid(spf_link_if_i.valid), .ready(spf_link_if_i.ready), .data(spf_link_if_i.data),
    .startofpacket(spf_link_if_i.startofpacket), .endofpacket(spf_link_if_i.endofpacket),
    .empty(spf_link_if_i.empty));
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; a source write stalls while its buffer is full, so the wait is long.
  task automatic apb(input bit snk, input bit wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel_src <= !snk;
    psel_snk <= snk;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while ((snk ? snk_pready : src_pready) !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      miscompares++;
      wrap_up();
    end
    rd = snk ? snk_prdata : src_prdata;
    er = snk ? snk_pslverr : src_pslverr;
    psel_src <= 1'b0;
    psel_snk <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic send(input logic s, input logic e, input logic [1:0] em, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(0, 1, 12'h000, {26'h0, em, 2'b00, e, s}, rd, er);
    apb(0, 1, 12'h004, d, rd, er);
  endtask
  // Waits for a held beat, checks its flags and empty, then pops it with a data read and checks the word.
  task automatic pop(input logic s, input logic e, input logic [1:0] em, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    int n;
    n = 0;
    do begin
      apb(1, 0, 12'h008, 32'h0, rd, er);
      n++;
    end while (rd[3] !== 1'b1 && n < 50);
    if (rd[3] !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
    chk("sink status", {22'h0, (e ? em : 2'b00), 2'b00, e, s, 1'b1, 3'h0}, rd & 32'h0000_0338);
    apb(1, 0, 12'h004, 32'h0, rd, er);
    chk("sink data", d, rd);
  endtask
  task automatic t_packet17();
    for (int i = 0; i < 5; i++) begin
      send(i == 0, i == 4, (i == 4) ? 2'h3 : 2'h0, 32'h1020_3040 + i);
      pop(i == 0, i == 4, (i == 4) ? 2'h3 : 2'h0, 32'h1020_3040 + i);
    end
  endtask
  task automatic t_stall();
    for (int i = 0; i < 3; i++) begin
      send(1, 1, 2'(i), 32'hA0B0_C0D0 + i);
    end
    for (int i = 0; i < 3; i++) begin
      pop(1, 1, 2'(i), 32'hA0B0_C0D0 + i);
    end
  endtask
  task automatic t_restart();
    logic [31:0] rd;
    logic er;
    send(1, 0, 2'h0, 32'h1111_1111);
    send(1, 0, 2'h0, 32'h2222_2222);
    send(0, 1, 2'h1, 32'h3333_3333);
    pop(1, 0, 2'h0, 32'h1111_1111);
    pop(0, 1, 2'h1, 32'h3333_3333);
    apb(0, 0, 12'h008, 32'h0, rd, er);
    chk("source status", 32'h4, rd & 32'h7);
    apb(0, 1, 12'h008, 32'h4, rd, er);
    apb(0, 0, 12'h008, 32'h0, rd, er);
    chk("source err cleared", 32'h0, rd & 32'h4);
  endtask
  task automatic t_regs();
    logic [31:0] rd;
    logic er;
    apb(0, 1, 12'h000, 32'h0000_0033, rd, er);
    apb(0, 0, 12'h000, 32'h0, rd, er);
    chk("source ctrl", 32'h33, rd & 32'h33);
    apb(0, 0, 12'h00C, 32'h0, rd, er);
    chk("source count", 32'h0000_000A, rd);
    apb(1, 0, 12'h00C, 32'h0, rd, er);
    chk("sink count", 32'h0000_000A, rd);
    for (int k = 0; k < 2; k++) begin
      apb(k == 1, 0, 12'h010, 32'h0, rd, er);
      chk("unmapped pslverr", 32'h1, {31'h0, er});
    end
  endtask
  // An end beat with no open packet is passed on by the source and flagged by the sink.
  task automatic t_orphan();
    logic [31:0] rd;
    logic er;
    send(0, 1, 2'h2, 32'h4455_6677);
    pop(0, 1, 2'h2, 32'h4455_6677);
    apb(1, 0, 12'h008, 32'h0, rd, er);
    chk("sink err", 32'h4, rd & 32'h6);
    apb(1, 1, 12'h000, 32'h4, rd, er);
    apb(1, 0, 12'h008, 32'h0, rd, er);
    chk("sink err cleared", 32'h0, rd & 32'h6);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_packet17();
    t_stall();
    t_restart();
    t_regs();
    t_orphan();
    wrap_up();
  end
endmodule
`default_nettype wire

/* verilog/spf_link_if.sv */
// Packet stream link between a source end and a sink end.
// Assumes both ends share pclk; no clocking block.
`default_nettype none
interface spf_link_if #(
  parameter int DATA_W = 32,
  parameter int EMPTY_W = 2
) (
  input wire logic pclk
);
  logic valid;
  logic ready;
  logic [DATA_W-1:0] data;
  logic startofpacket;
  logic endofpacket;
  logic [EMPTY_W-1:0] empty;
  modport source (
    input pclk,
    input ready,
    output valid,
    output data,
    output startofpacket,
    output endofpacket,
    output empty
  );
  modport sink (
    input pclk,
    input valid,
    input data,
    input startofpacket,
    input endofpacket,
    input empty,
    output ready
  );
endinterface
`default_nettype wire

/* verilog/spf_params.svh */
// Constants shared by the packet stream source and sink ends.
// Assumes inclusion by bare name from files under verilog/.
`ifndef SPF_PARAMS_SVH
`define SPF_PARAMS_SVH
`define SPF_BITS_IN_EACH_SYMBOL 8
`define SPF_SYMBOLS_IN_EACH_BEAT 4
`define SPF_READY_LEAD_CYCLES 0
`define SPF_MAX_LEAD 8
`define SPF_APB_ADDR_W 12
`define SPF_REG_CTRL 12'h000
`define SPF_REG_DATA 12'h004
`define SPF_REG_STATUS 12'h008
`define SPF_REG_COUNT 12'h00C
`define SPF_CTRL_SOP_BIT 0
`define SPF_CTRL_EOP_BIT 1
`define SPF_CTRL_EMPTY_LSB 4
`define SPF_STAT_SRC_BUSY_BIT 0
`define SPF_STAT_IN_PKT_BIT 1
`define SPF_STAT_ERR_BIT 2
`define SPF_STAT_VALID_BIT 3
`define SPF_STAT_SOP_BIT 4
`define SPF_STAT_EOP_BIT 5
`define SPF_STAT_EMPTY_LSB 8
`endif

/* verilog/spf_pkg.sv */
// Types shared by both ends of the packet stream link.
// Assumes spf_params.svh is reachable on the include path.
`default_nettype none
package spf_pkg;
  typedef enum logic [1:0] {
    spf_idle,
    spf_in_packet
  } spf_pkt_state_type;
endpackage
`default_nettype wire

/* verilog/spf_sink.sv */
// Packet stream sink end: takes beats, reports them over APB.
// Assumes an APB master on pclk and a source end on the link interface.
`default_nettype none
`include "spf_params.svh"
module spf_sink #(
  parameter int SYMS = `SPF_SYMBOLS_IN_EACH_BEAT,
  parameter int SYM_W = `SPF_BITS_IN_EACH_SYMBOL,
  parameter int LEAD = `SPF_READY_LEAD_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  spf_link_if.sink link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SPF_APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import spf_pkg::*;
  localparam int DW = SYMS * SYM_W;
  localparam int EW = (SYMS > 1) ? $clog2(SYMS) : 1;
  // A beat is held until software reads the data register; ready drops meanwhile.
  logic full_q, full_d;
  logic [DW-1:0] data_q;
  logic sop_q, eop_q;
  logic [EW-1:0] empty_q;
  logic err_q;
  logic [15:0] beats_q;
  logic ready_q;
  spf_pkt_state_type st_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  wire take = link.valid && (LEAD == 0 ? ready_q : 1'b1);
  wire bad_sop = take && link.startofpacket && st_q == spf_in_packet;
  wire bad_start = take && !link.startofpacket && st_q == spf_idle;
  wire acc = psel && penable && !pready_q;
  wire sel_data = paddr == `SPF_REG_DATA;
  wire sel_stat = paddr == `SPF_REG_STATUS;
  wire sel_cnt = paddr == `SPF_REG_COUNT;
  wire sel_ctrl = paddr == `SPF_REG_CTRL;
  wire pop = acc && !pwrite && sel_data && full_q;
  wire clr_err = acc && pwrite && sel_ctrl && pwdata[`SPF_STAT_ERR_BIT];
  wire [EW-1:0] empty_in = link.endofpacket ? link.empty : '0;
  logic [31:0] stat_w;
  always_comb begin
    stat_w = '0;
    stat_w[`SPF_STAT_VALID_BIT] = full_q;
    stat_w[`SPF_STAT_IN_PKT_BIT] = st_q == spf_in_packet;
    stat_w[`SPF_STAT_ERR_BIT] = err_q;
    stat_w[`SPF_STAT_SOP_BIT] = sop_q;
    stat_w[`SPF_STAT_EOP_BIT] = eop_q;
    stat_w[`SPF_STAT_EMPTY_LSB +: EW] = empty_q;
  end
  wire [31:0] rd_w = sel_data ? 32'(data_q) : sel_stat ? stat_w : sel_cnt ? {16'h0000, beats_q} : 32'h0000_0000;
  wire unmapped = !(sel_data || sel_stat || sel_cnt || sel_ctrl);
  // Ready is not reissued while an earlier one may still bring a beat, so the one holding slot cannot overrun.
  logic ready_owed;
  if (LEAD < 2) begin : g_owed_none
    assign ready_owed = 1'b0;
  end else begin : g_owed_pipe
    logic [LEAD-2:0] owed_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        owed_q <= '0;
      end else begin
        owed_q <= (LEAD-1)'({owed_q, ready_q});
      end
    end
    assign ready_owed = |owed_q;
  end
  wire ready_next = !full_d && !take && !((LEAD > 0) && ready_q) && !ready_owed;
  always_comb begin
    full_d = full_q;
    if (take) begin
      full_d = 1'b1;
    end else if (pop) begin
      full_d = 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      full_q <= full_d;
      ready_q <= ready_next;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= '0;
      sop_q <= 1'b0;
      eop_q <= 1'b0;
      empty_q <= '0;
      beats_q <= 16'h0000;
    end else if (take) begin
      data_q <= link.data;
      sop_q <= link.startofpacket;
      eop_q <= link.endofpacket;
      empty_q <= empty_in;
      beats_q <= beats_q + 16'h0001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= spf_idle;
    end else if (take) begin
      case (st_q)
        spf_idle: st_q <= link.endofpacket ? spf_idle : spf_in_packet;
        spf_in_packet: st_q <= link.endofpacket ? spf_idle : spf_in_packet;
        default: st_q <= spf_idle;
      endcase
    end
  end
  // Set wins over software clear so a protocol slip is never lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (bad_sop || bad_start) begin
      err_q <= 1'b1;
    end else if (clr_err) begin
      err_q <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= acc;
      pslverr_q <= acc && unmapped;
      if (acc && !pwrite) begin
        prdata_q <= rd_w;
      end
    end
  end
  assign link.ready = ready_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule
`default_nettype wire

/* verilog/spf_source.sv */
// Packet stream source end: software loads beats over APB, a two-entry buffer feeds the link.
// Assumes an APB master on pclk and a sink end on the link interface.
//
// The address map and the APB register port were decided locally.
`default_nettype none
`include "spf_params.svh"
module spf_source #(
  parameter int SYMS = `SPF_SYMBOLS_IN_EACH_BEAT,
  parameter int SYM_W = `SPF_BITS_IN_EACH_SYMBOL,
  parameter int LEAD = `SPF_READY_LEAD_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  spf_link_if.source link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SPF_APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import spf_pkg::*;
  localparam int DW = SYMS * SYM_W;
  localparam int EW = (SYMS > 1) ? $clog2(SYMS) : 1;
  localparam int BW = DW + EW + 2;
  // Control register: sideband for the next beat, applied when DATA is written.
  logic ctl_sop_q, ctl_eop_q;
  logic [EW-1:0] ctl_empty_q;
  // Two-entry buffer; the APB write stalls while it is full.
  logic [BW-1:0] buf_q [2];
  logic wptr_q, rptr_q;
  logic [1:0] cnt_q;
  logic valid_q;
  logic [BW-1:0] beat_q;
  logic err_q;
  spf_pkt_state_type st_q;
  logic [15:0] sent_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  wire acc = psel && penable && !pready_q;
  wire sel_ctrl = paddr == `SPF_REG_CTRL;
  wire sel_data = paddr == `SPF_REG_DATA;
  wire sel_stat = paddr == `SPF_REG_STATUS;
  wire sel_cnt = paddr == `SPF_REG_COUNT;
  wire unmapped = !(sel_ctrl || sel_data || sel_stat || sel_cnt);
  wire buf_full = cnt_q == 2'h2;
  wire buf_empty = cnt_q == 2'h0;
  wire data_wr = acc && pwrite && sel_data;
  // A full buffer holds the write in its access phase instead of refusing it, so no beat is lost.
  wire stall = data_wr && buf_full;
  // Beats that would open a packet inside another one are dropped and flagged.
  wire pend_in_pkt = st_q == spf_in_packet;
  wire push = data_wr && !buf_full;
  wire [BW-1:0] push_word = {ctl_sop_q, ctl_eop_q, ctl_empty_q, pwdata[DW-1:0]};
  wire [BW-1:0] head = buf_q[rptr_q];
  wire head_sop = head[BW-1];
  wire head_eop = head[BW-2];
  wire head_bad = head_sop && pend_in_pkt;
  // With zero lead a beat is held until ready; otherwise one beat per ready cycle.
  // The next cycle is a ready cycle when ready was high lead minus one cycles ago.
  // Valid is registered one edge ahead, so it lands exactly on that ready cycle.
  logic ready_cycle;
  if (LEAD < 2) begin : g_rdy_now
    assign ready_cycle = link.ready;
  end else begin : g_rdy_late
    logic [LEAD-2:0] rdy_pipe_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rdy_pipe_q <= '0;
      end else begin
        rdy_pipe_q <= (LEAD-1)'({rdy_pipe_q, link.ready});
      end
    end
    assign ready_cycle = rdy_pipe_q[LEAD-2];
  end
  wire hold = (LEAD == 0) && valid_q && !link.ready;
  wire ready_cycle_ok = (LEAD == 0) ? 1'b1 : ready_cycle;
  wire fire = !hold && ready_cycle_ok && !buf_empty && !head_bad;
  wire drop = !hold && !buf_empty && head_bad;
  wire pop = fire || drop;
  logic [31:0] stat_w;
  logic [31:0] ctrl_w;
  // Busy stays high until the last beat has left the link, not just the buffer.
  always_comb begin
    stat_w = 32'h0000_0000;
    stat_w[`SPF_STAT_SRC_BUSY_BIT] = !buf_empty || valid_q;
    stat_w[`SPF_STAT_IN_PKT_BIT] = pend_in_pkt;
    stat_w[`SPF_STAT_ERR_BIT] = err_q;
  end
  always_comb begin
    ctrl_w = 32'h0000_0000;
    ctrl_w[`SPF_CTRL_SOP_BIT] = ctl_sop_q;
    ctrl_w[`SPF_CTRL_EOP_BIT] = ctl_eop_q;
    ctrl_w[`SPF_CTRL_EMPTY_LSB +: EW] = ctl_empty_q;
  end
  wire [31:0] rd_w = sel_ctrl ? ctrl_w : sel_stat ? stat_w : sel_cnt ? {16'h0000, sent_q} : 32'h0000_0000;
  // The control fields stay set across beats, so software rewrites them only when they change.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_sop_q <= 1'b0;
      ctl_eop_q <= 1'b0;
      ctl_empty_q <= '0;
    end else if (acc && pwrite && sel_ctrl) begin
      ctl_sop_q <= pwdata[`SPF_CTRL_SOP_BIT];
      ctl_eop_q <= pwdata[`SPF_CTRL_EOP_BIT];
      ctl_empty_q <= pwdata[`SPF_CTRL_EMPTY_LSB +: EW];
    end
  end
  // One flip-flop slot per entry, written only when the write pointer names it.
  for (genvar e = 0; e < 2; e++) begin : g_slot
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        buf_q[e] <= '0;
      end else if (push && wptr_q == 1'(e)) begin
        buf_q[e] <= push_word;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wptr_q <= !wptr_q;
      end
      if (pop) begin
        rptr_q <= !rptr_q;
      end
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_q <= 1'b0;
      beat_q <= '0;
      st_q <= spf_idle;
      sent_q <= 16'h0000;
    end else begin
      if (!hold) begin
        valid_q <= fire;
        if (fire) begin
          beat_q <= head;
          sent_q <= sent_q + 16'h0001;
          // Packet state follows launched beats, so a stalled link still blocks a second start.
          case (st_q)
            spf_idle: st_q <= (head_sop && !head_eop) ? spf_in_packet : spf_idle;
            spf_in_packet: st_q <= head_eop ? spf_idle : spf_in_packet;
            default: st_q <= spf_idle;
          endcase
        end
      end
    end
  end
  // The error flag is sticky: a drop in the same cycle as a software clear wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (drop) begin
      err_q <= 1'b1;
    end else if (acc && pwrite && sel_stat && pwdata[`SPF_STAT_ERR_BIT]) begin
      err_q <= 1'b0;
    end
  end
  // Read data and pready are registered, so every access has one wait state unless it stalls.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= acc && !stall;
      pslverr_q <= acc && !stall && unmapped;
      if (acc && !pwrite) begin
        prdata_q <= rd_w;
      end
    end
  end
  // Every link output comes straight from the launch register.
  assign link.valid = valid_q;
  assign link.data = beat_q[DW-1:0];
  assign link.empty = beat_q[DW +: EW];
  assign link.endofpacket = beat_q[BW-2];
  assign link.startofpacket = beat_q[BW-1];
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule
`default_nettype wire
